/* File: pkg/iid_pkg.sv */
// package: register map, field layout and timing for the isolated input debounce block
package iid_pkg;

    // ------------------------------------------------------------
    // channel counts
    // ------------------------------------------------------------
    localparam int MAIN_INPUTS = 6;
    localparam int EXTRA_INPUTS = 8;
    localparam int NUM_INPUTS = 14;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_RAW = 8'h08;
    localparam logic [7:0] OFS_DERIVED = 8'h0C;
    localparam logic [7:0] OFS_DELAY_BASE = 8'h10;
    localparam logic [7:0] OFS_DELAY_LAST = 8'h44;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_EXTRA_BIT = 0;
    localparam int DLY_AC_BIT = 8;
    localparam int DERIVED_BREAKER_BIT = 0;
    localparam int DERIVED_PERMISSIVE_BIT = 1;
    localparam logic [7:0] DELAY_MAX_HUNDREDTHS = 8'hC8;
    localparam logic [7:0] DELAY_RESET_HUNDREDTHS = 8'h00;
    localparam logic CTRL_EXTRA_RESET = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // qualification counts, in sixteenth-cycle samples
    // ------------------------------------------------------------
    localparam logic [5:0] AC_PICKUP_SAMPLES = 6'h02;
    localparam logic [5:0] AC_DROPOUT_SAMPLES = 6'h10;
    localparam logic [1:0] SAMPLES_PER_INTERVAL_M1 = 2'h3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int SAMPLE_PERIOD_NS = 1041667;
    localparam int SAMPLE_CLOCKS = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

    // per-input setting carried to a channel
    typedef struct packed {
        logic acMode;
        logic [7:0] hundredths;
    } iid_delay_t;

    // per-input qualification limit after rounding
    typedef struct packed {
        logic acMode;
        logic [5:0] sixteenths;
    } iid_limit_t;

endpackage

/* File: hdl/iid_debounce_chan.sv */
// one input channel: timed or ac-mode pickup/dropout qualification
`timescale 1ns/1ps
`default_nettype none

module iid_debounce_chan
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // sample timing and data
    input wire logic sampleTick,
    input wire logic inSync,
    input wire iid_pkg::iid_limit_t limit,
    // qualified state
    output logic qualified
);

    logic state_q;
    logic state_d;
    logic [5:0] run_q;
    logic [5:0] run_d;
    logic [5:0] runNext;
    logic [5:0] threshold;
    logic differs;
    logic reached;

    // ------------------------------------------------------------
    // threshold selection
    // ------------------------------------------------------------
    // one limit for both directions in timed mode; ac mode is asymmetric
    assign threshold = limit.acMode
        ? (state_q ? iid_pkg::AC_DROPOUT_SAMPLES : iid_pkg::AC_PICKUP_SAMPLES)
        : limit.sixteenths;
    assign differs = inSync != state_q;
    assign runNext = run_q + 6'h01;
    // a zero limit still waits for the sample that shows the change
    assign reached = runNext >= threshold;

    // ------------------------------------------------------------
    // qualification counter
    // ------------------------------------------------------------
    // any agreeing sample restarts the count, so qualification is consecutive
    assign run_d = (!sampleTick) ? run_q : ((differs && !reached) ? runNext : 6'h00);
    assign state_d = (sampleTick && differs && reached) ? inSync : state_q;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            run_q <= 6'h00;
            state_q <= 1'b0;
        end
        else
        begin
            run_q <= run_d;
            state_q <= state_d;
        end
    end

    assign qualified = state_q;

endmodule
`default_nettype wire

/* File: hdl/isolated_input_debounce.sv */
// top: input sampling, debounce channels, quarter-cycle publishing and AXI4-Lite registers
//
// Notes on behaviour
// - One delay setting per input serves both pickup and dropout.
// - Delay range is zero to two cycles, or ac qualification mode instead.
// - Delay rounds to nearest sixteenth cycle; timer steps once per sixteenth-cycle sample.
// - AC mode: assert after two high samples, deassert after sixteen low samples.
// - AC mode pickup within 0.75 cycle, dropout within 1.25 cycles.
// - Timers run every sample; published status bits refresh each quarter cycle.
// - Raw sampled input state is captured ahead of debounce.
// - Default delay is zero cycles, inputs pass without extra delay.
// - Six mainboard inputs plus eight extra-board inputs when fitted.
// - Permissive trip received follows input two by default.
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module isolated_input_debounce
#(
    parameter int SAMPLE_DIV = iid_pkg::SAMPLE_CLOCKS
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // field inputs, asynchronous
    input wire logic [13:0] fieldIn,
    // published and raw status
    output logic [13:0] inputStatus,
    output logic [13:0] rawStatus,
    output logic breakerClosedStatus,
    output logic permissiveTripReceived,
    // axi4-lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    // axi4-lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    // axi4-lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);

    localparam int N = iid_pkg::NUM_INPUTS;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic isDelayAddr(input logic [7:0] addr);
        isDelayAddr = (addr >= iid_pkg::OFS_DELAY_BASE) && (addr <= iid_pkg::OFS_DELAY_LAST)
            && (addr[1:0] == 2'h0);
    endfunction

    function automatic logic [3:0] delayIndex(input logic [7:0] addr);
        logic [7:0] rel;
        rel = addr - iid_pkg::OFS_DELAY_BASE;
        delayIndex = rel[5:2];
    endfunction

    function automatic logic isMapped(input logic [7:0] addr);
        isMapped = isDelayAddr(addr) || (addr == iid_pkg::OFS_CONTROL) || (addr == iid_pkg::OFS_STATUS)
            || (addr == iid_pkg::OFS_RAW) || (addr == iid_pkg::OFS_DERIVED);
    endfunction

    // nearest sixteenth of a cycle from hundredths; ties round up
    function automatic logic [5:0] toSixteenths(input logic [7:0] hundredths);
        logic [12:0] scaled;
        scaled = {5'h00, hundredths} * 13'd16 + 13'd50;
        toSixteenths = 6'(scaled / 13'd100);
    endfunction

    // ------------------------------------------------------------
    // input synchroniser
    // ------------------------------------------------------------
    logic [13:0] syncA_q;
    logic [13:0] syncB_q;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            syncA_q <= 14'h0000;
            syncB_q <= 14'h0000;
        end
        else
        begin
            syncA_q <= fieldIn;
            syncB_q <= syncA_q;
        end
    end

    // ------------------------------------------------------------
    // sample and processing-interval timebase
    // ------------------------------------------------------------
    logic [31:0] divCnt_q;
    logic [1:0] sampleCnt_q;
    logic sampleTick;
    logic intervalTick;

    assign sampleTick = divCnt_q == 32'(SAMPLE_DIV - 1);
    assign intervalTick = sampleTick && (sampleCnt_q == iid_pkg::SAMPLES_PER_INTERVAL_M1);

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            divCnt_q <= 32'h00000000;
            sampleCnt_q <= 2'h0;
        end
        else
        begin
            divCnt_q <= sampleTick ? 32'h00000000 : divCnt_q + 32'h00000001;
            sampleCnt_q <= sampleTick ? sampleCnt_q + 2'h1 : sampleCnt_q;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    iid_pkg::iid_delay_t delay_q [N];
    logic extraFitted_q;

    // ------------------------------------------------------------
    // debounce channels
    // ------------------------------------------------------------
    logic [13:0] qualified;
    logic [13:0] boardMask;

    // extra-board inputs read as deasserted while the board is absent
    assign boardMask = extraFitted_q ? 14'h3FFF : 14'h003F;

    generate
        for (genvar i = 0; i < N; i++)
        begin : g_chan
            iid_pkg::iid_limit_t limit;
            assign limit.acMode = delay_q[i].acMode;
            assign limit.sixteenths = toSixteenths(delay_q[i].hundredths);

            iid_debounce_chan u_chan
            (
                .sys_clk(sys_clk),
                .rstn(rstn),
                .sampleTick(sampleTick),
                .inSync(syncB_q[i]),
                .limit(limit),
                .qualified(qualified[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // raw capture and published status
    // ------------------------------------------------------------
    logic [13:0] raw_q;
    logic [13:0] status_q;
    logic breaker_q;
    logic permissive_q;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            raw_q <= 14'h0000;
            status_q <= 14'h0000;
            breaker_q <= 1'b0;
            permissive_q <= 1'b0;
        end
        else
        begin
            if (sampleTick)
                raw_q <= syncB_q & boardMask;
            if (intervalTick)
            begin
                status_q <= qualified & boardMask;
                breaker_q <= qualified[0];
                permissive_q <= qualified[1];
            end
        end
    end

    assign inputStatus = status_q;
    assign rawStatus = raw_q;
    assign breakerClosedStatus = breaker_q;
    assign permissiveTripReceived = permissive_q;

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    logic awready_q;
    logic awHeld_q;
    logic [7:0] awAddr_q;
    logic wready_q;
    logic wHeld_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic awTake;
    logic wTake;
    logic doWrite;
    logic awHeld_d;
    logic wHeld_d;
    logic bvalid_d;
    logic writeDelay;
    logic [3:0] writeIdx;
    logic [7:0] clampedHundredths;

    // address and data are taken in either order; the write lands once both are held
    assign awTake = s_axi_awvalid && awready_q;
    assign wTake = s_axi_wvalid && wready_q;
    assign doWrite = awHeld_q && wHeld_q && !bvalid_q;
    assign awHeld_d = doWrite ? 1'b0 : (awHeld_q || awTake);
    assign wHeld_d = doWrite ? 1'b0 : (wHeld_q || wTake);
    assign bvalid_d = doWrite ? 1'b1 : (bvalid_q && !s_axi_bready);
    assign writeDelay = doWrite && isDelayAddr(awAddr_q);
    assign writeIdx = delayIndex(awAddr_q);
    // entries above two cycles saturate at the top of the range
    assign clampedHundredths = (wData_q[7:0] > iid_pkg::DELAY_MAX_HUNDREDTHS)
        ? iid_pkg::DELAY_MAX_HUNDREDTHS : wData_q[7:0];

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            awready_q <= 1'b0;
            awHeld_q <= 1'b0;
            awAddr_q <= 8'h00;
            wready_q <= 1'b0;
            wHeld_q <= 1'b0;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= iid_pkg::RESP_OKAY;
        end
        else
        begin
            awready_q <= !awHeld_d && !bvalid_d;
            wready_q <= !wHeld_d && !bvalid_d;
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            bvalid_q <= bvalid_d;
            if (awTake)
                awAddr_q <= s_axi_awaddr;
            if (wTake)
            begin
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (doWrite)
                bresp_q <= isMapped(awAddr_q) ? iid_pkg::RESP_OKAY : iid_pkg::RESP_SLVERR;
        end
    end

    // per-input delay settings and board control
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int k = 0; k < N; k++)
            begin
                delay_q[k].hundredths <= iid_pkg::DELAY_RESET_HUNDREDTHS;
                delay_q[k].acMode <= 1'b0;
            end
            extraFitted_q <= iid_pkg::CTRL_EXTRA_RESET;
        end
        else
        begin
            if (writeDelay && wStrb_q[0])
                delay_q[writeIdx].hundredths <= clampedHundredths;
            if (writeDelay && wStrb_q[1])
                delay_q[writeIdx].acMode <= wData_q[iid_pkg::DLY_AC_BIT];
            if (doWrite && (awAddr_q == iid_pkg::OFS_CONTROL) && wStrb_q[0])
                extraFitted_q <= wData_q[iid_pkg::CTRL_EXTRA_BIT];
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic arTake;
    logic rvalid_d;
    logic [31:0] readMux;
    logic [3:0] readIdx;
    logic [31:0] delayWord;

    assign arTake = s_axi_arvalid && arready_q;
    assign rvalid_d = arTake ? 1'b1 : (rvalid_q && !s_axi_rready);
    assign readIdx = delayIndex(s_axi_araddr);
    assign delayWord = {23'h000000, delay_q[readIdx].acMode, delay_q[readIdx].hundredths};
    assign readMux = isDelayAddr(s_axi_araddr) ? delayWord
        : (s_axi_araddr == iid_pkg::OFS_CONTROL) ? {31'h00000000, extraFitted_q}
        : (s_axi_araddr == iid_pkg::OFS_STATUS) ? {18'h00000, status_q}
        : (s_axi_araddr == iid_pkg::OFS_RAW) ? {18'h00000, raw_q}
        : (s_axi_araddr == iid_pkg::OFS_DERIVED) ? {30'h00000000, permissive_q, breaker_q}
        : 32'h00000000;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= iid_pkg::RESP_OKAY;
        end
        else
        begin
            arready_q <= !rvalid_d;
            rvalid_q <= rvalid_d;
            if (arTake)
            begin
                rdata_q <= readMux;
                rresp_q <= isMapped(s_axi_araddr) ? iid_pkg::RESP_OKAY : iid_pkg::RESP_SLVERR;
            end
        end
    end

    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule
`default_nettype wire

/* File: sim/iid_debounce_assertions.sv */
// checker: port-level properties of the isolated input debounce block
`timescale 1ns/1ps
`default_nettype none

module iid_debounce_assertions
#(
    parameter int SAMPLE_DIV = 4
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // field and status
    input wire logic [13:0] fieldIn,
    input wire logic [13:0] inputStatus,
    input wire logic [13:0] rawStatus,
    input wire logic breakerClosedStatus,
    input wire logic permissiveTripReceived,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // ----------------------------------------
    // clocks since the published word moved
    // ----------------------------------------
    logic [13:0] prevStatus_q;
    logic [31:0] gap_q;
    wire statusMoved = (inputStatus != prevStatus_q);

    // saturated: no known interval start after reset
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            prevStatus_q <= 14'h0;
            gap_q <= 32'hFFFF;
        end
        else
        begin
            prevStatus_q <= inputStatus;
            gap_q <= statusMoved ? 32'h1 : ((gap_q < 32'hFFFF) ? gap_q + 32'h1 : gap_q);
        end
    end

    a_status_gap: assert property (statusMoved |-> gap_q >= 4 * SAMPLE_DIV)
        else $error("published status moved inside a processing interval");
    a_breaker_follow: assert property (breakerClosedStatus == inputStatus[0])
        else $error("breaker status differs from input one");
    a_permissive_follow: assert property (permissiveTripReceived == inputStatus[1])
        else $error("permissive trip differs from input two");
    a_reset_clear: assert property ($rose(rstn) |-> inputStatus == 14'h0 && !breakerClosedStatus)
        else $error("status not clear after reset");
    a_raw_source: assert property ($changed(rawStatus[5:0]) |-> rawStatus[5:0] == $past(fieldIn[5:0], 3))
        else $error("raw status not the synchronised field input");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_awready_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
        else $error("address ready during open write");
endmodule

bind isolated_input_debounce iid_debounce_assertions #(.SAMPLE_DIV(SAMPLE_DIV)) u_iid_chk (.*);
`default_nettype wire

/* File: sim/iid_field_model.sv */
// field contact model: steady, chattering or ac-energised isolated inputs
`timescale 1ns/1ps
`default_nettype none

module iid_field_model
#(
    parameter int SAMPLE_DIV = 4
)
(
    // clock
    input wire logic sys_clk,
    // per-input contact behaviour
    input wire logic [13:0] level,
    input wire logic [13:0] acOn,
    input wire logic [13:0] bounce,
    // energised state seen by the block
    output logic [13:0] fieldIn
);
    // ----------------------------------------
    // sixteenth-cycle phase of the power system
    // ----------------------------------------
    int divCnt = 32'h0;
    logic [3:0] phase = 4'h0;
    // rectified ac sits above threshold for 12 of 16 samples
    wire aboveThr = (phase < 4'hC);

    always @(posedge sys_clk)
    begin
        if (divCnt == SAMPLE_DIV - 1)
        begin
            divCnt <= 32'h0;
            phase <= phase + 4'h1;
        end
        else
            divCnt <= divCnt + 32'h1;
    end

    // chatter flips every sample so no two consecutive samples agree
    assign fieldIn = (acOn & {14{aboveThr}}) | (~acOn & bounce & {14{phase[0]}}) | (~acOn & ~bounce & level);
endmodule
`default_nettype wire

/* File: sim/tb_isolated_input_debounce.sv */
// testbench: registers, debounce timing, ac mode, raw capture and extra board
`timescale 1ns/1ps
`default_nettype none

module tb_isolated_input_debounce;
    localparam int DIV = 4;
    localparam logic [1:0] okResp = iid_pkg::RESP_OKAY;
    localparam logic [1:0] errResp = iid_pkg::RESP_SLVERR;
    logic sys_clk, rstn, breakerClosedStatus, permissiveTripReceived;
    logic [13:0] level, acOn, bounce, fieldIn, inputStatus, rawStatus;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int n_errors = 0;
    int samples_checked = 0;

    isolated_input_debounce #(.SAMPLE_DIV(DIV)) u_dut (.*);
    iid_field_model #(.SAMPLE_DIV(DIV)) u_field (.sys_clk, .level, .acOn, .bounce, .fieldIn);

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // checking and bus tasks
    // ----------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chkStat(input logic [13:0] e);
        check("inputStatus", {18'h0, e}, {18'h0, inputStatus});
    endtask

    task automatic bound(input int n);
        if (n >= 200)
        begin
            n_errors++;
            $display("[ERR] handshake expected answer seen timeout");
            give_verdict();
        end
    endtask

    function automatic logic [7:0] dly(input int i);
        return iid_pkg::OFS_DELAY_BASE + 8'(4 * i);
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er, input int lag);
        int n = 0;
        bit aw = 1'b0, w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw && w) && n < 200)
        begin
            @(posedge sys_clk);
            n++;
            if (!aw && s_axi_awready)
            begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready)
            begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        repeat (lag) @(posedge sys_clk);
        s_axi_bready <= 1'b1;
        do
            @(posedge sys_clk);
        while (!s_axi_bvalid && ++n < 200);
        s_axi_bready <= 1'b0;
        bound(n);
        check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er, input int lag);
        int n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
            @(posedge sys_clk);
        while (!s_axi_arready && ++n < 200);
        s_axi_arvalid <= 1'b0;
        repeat (lag) @(posedge sys_clk);
        s_axi_rready <= 1'b1;
        do
            @(posedge sys_clk);
        while (!s_axi_rvalid && ++n < 200);
        s_axi_rready <= 1'b0;
        bound(n);
        check("rdata", ed, s_axi_rdata);
        check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_registers();
        chkStat(14'h0);
        rd(iid_pkg::OFS_CONTROL, 32'h0, okResp, 0);
        for (int i = 0; i < 14; i++)
            rd(dly(i), 32'h0, okResp, 0);
        rd(8'h48, 32'h0, errResp, 3);
        wr(8'h48, 32'h55, errResp, 2);
        wr(dly(0), 32'hFF, okResp, 0);
        rd(dly(0), {24'h0, iid_pkg::DELAY_MAX_HUNDREDTHS}, okResp, 0);
        wr(dly(0), 32'h0, okResp, 0);
        $display("test registers done");
    endtask

    task automatic t_zero();
        level <= 14'h003F;
        repeat (44) @(posedge sys_clk);
        chkStat(14'h3F);
        check("breaker", 32'h1, {31'h0, breakerClosedStatus});
        check("permissive", 32'h1, {31'h0, permissiveTripReceived});
        rd(iid_pkg::OFS_DERIVED, 32'h3, okResp, 0);
        rd(iid_pkg::OFS_RAW, 32'h3F, okResp, 0);
        level <= 14'h0;
        repeat (44) @(posedge sys_clk);
        chkStat(14'h0);
        $display("test zero delay done");
    endtask

    task automatic t_timed();
        wr(dly(2), 32'h50, okResp, 0);
        for (int k = 0; k < 2; k++)
        begin
            level <= k ? 14'h0 : 14'h4;
            repeat (50) @(posedge sys_clk);
            chkStat(k ? 14'h4 : 14'h0);
            repeat (44) @(posedge sys_clk);
            chkStat(k ? 14'h0 : 14'h4);
        end
        $display("test timed delay done");
    endtask

    task automatic t_ac();
        wr(dly(1), 32'h100, okResp, 0);
        acOn <= 14'h0002;
        repeat (84) @(posedge sys_clk);
        check("ac pickup", 32'h1, {31'h0, permissiveTripReceived});
        for (int k = 0; k < 16; k++)
        begin
            repeat (4) @(posedge sys_clk);
            check("ac hold", 32'h1, {31'h0, permissiveTripReceived});
        end
        acOn <= 14'h0;
        repeat (44) @(posedge sys_clk);
        check("ac early drop", 32'h1, {31'h0, permissiveTripReceived});
        repeat (72) @(posedge sys_clk);
        check("ac dropout", 32'h0, {31'h0, permissiveTripReceived});
        $display("test ac mode done");
    endtask

    task automatic t_extra();
        level <= 14'h3FC0;
        repeat (44) @(posedge sys_clk);
        chkStat(14'h0);
        wr(iid_pkg::OFS_CONTROL, 32'h1, okResp, 0);
        repeat (44) @(posedge sys_clk);
        chkStat(14'h3FC0);
        rd(iid_pkg::OFS_STATUS, 32'h3FC0, okResp, 0);
        level <= 14'h0;
        $display("test extra board done");
    endtask

    task automatic t_bounce();
        int n = 0;
        logic prev, seen = 1'b0;
        wr(dly(0), 32'h32, okResp, 0);
        bounce <= 14'h0001;
        prev = rawStatus[0];
        repeat (80)
        begin
            @(posedge sys_clk);
            n += (rawStatus[0] !== prev);
            prev = rawStatus[0];
            seen |= breakerClosedStatus;
        end
        bounce <= 14'h0;
        check("bounce breaker", 32'h0, {31'h0, seen});
        check("raw toggles", 32'h1, {31'h0, n >= 10});
        $display("test bounce done");
    endtask

    task automatic t_reset2();
        level <= 14'h0001;
        repeat (80) @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chkStat(14'h0);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rd(dly(2), 32'h0, okResp, 0);
        rd(iid_pkg::OFS_CONTROL, 32'h0, okResp, 0);
        level <= 14'h0;
        $display("test second reset done");
    endtask

    initial
    begin
        rstn = 1'b0;
        {level, acOn, bounce} = 42'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        t_registers();
        t_zero();
        t_timed();
        t_ac();
        t_extra();
        t_bounce();
        t_reset2();
        give_verdict();
    end
endmodule
`default_nettype wire
